// *** hdl/eipr_consts.svh ***
`ifndef EIPR_CONSTS_SVH
`define EIPR_CONSTS_SVH
// register byte offsets
`define EIPR_OFS_SEL3      8'h00
`define EIPR_OFS_SEL4      8'h04
`define EIPR_OFS_DCFG      8'h08
`define EIPR_OFS_DSTAT     8'h0C
// register reset values
`define EIPR_SEL_RST       5'h00
`define EIPR_DCFG_RST      4'h0
// debug configuration fields
`define EIPR_DCFG_DIS      0
`define EIPR_DCFG_REMAP    1
`define EIPR_DCFG_MISC_LO  2
`define EIPR_DCFG_MISC_HI  3
// debug status fields
`define EIPR_DST_FORCED    0
`define EIPR_DST_SWEN      1
`define EIPR_DST_BOOT      2
// pin indices: port A 0..7, port B 8..15, port C 16..23
`define EIPR_PIN_BOOT      5
`define EIPR_PIN_REG       7
`define EIPR_PIN_INT1      8
`define EIPR_PIN_INT2      14
`define EIPR_PIN_JTAG_RESET_PIN      16
`define EIPR_PIN_JTAG_DATA_OUT_PIN      18
`define EIPR_PIN_JTAG_DATA_IN_PIN      19
`define EIPR_PIN_SWDIO     20
`define EIPR_SEL_LIMIT     5'd24
// second timer channel pins, default and remapped
`define EIPR_TIM_DEF_C1    5'd0
`define EIPR_TIM_DEF_C2    5'd3
`define EIPR_TIM_DEF_C3    5'd1
`define EIPR_TIM_DEF_C4    5'd2
`define EIPR_TIM_REMAP_C1  5'd9
// pin mode codes
`define EIPR_MODE_ANALOG   4'h0
`define EIPR_MODE_OUT_PP   4'h1
`define EIPR_MODE_IN_FLT   4'h4
`define EIPR_MODE_OUT_OD   4'h5
`define EIPR_MODE_IN_PULL  4'h8
`define EIPR_MODE_ALT_PP   4'h9
`define EIPR_MODE_ALT_OD   4'hD
`endif

// *** hdl/eipr_pkg.sv ***
package eipr_pkg;
    localparam int NPIN = 24;
    // per-pin pad controls
    typedef struct packed {
        logic [NPIN-1:0] out_val;
        logic [NPIN-1:0] oe_n;
        logic [NPIN-1:0] pull_up;
        logic [NPIN-1:0] pull_down;
    } eipr_pad_t;
    // software-side pin configuration
    typedef struct packed {
        logic [NPIN-1:0][3:0] mode;
        logic [NPIN-1:0]      sw_out;
        logic [NPIN-1:0]      alt_out;
    } eipr_pincfg_t;
    // debugger requests
    typedef struct packed {
        logic jtag_req;
        logic sw_req;
        logic forced;
        logic jtag_tdo;
        logic swdio_out;
        logic swdio_oe_n;
    } eipr_dbg_t;
    // whole module state
    typedef struct packed {
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic [4:0]      sel3;
        logic [4:0]      sel4;
        logic [3:0]      dcfg;
        logic            boot_flag;
        logic            boot_done;
        logic [31:0]     prdata;
        logic [3:0]      ext_int;
        logic [3:0]      tim_in;
    } eipr_state_t;
endpackage

// *** hdl/eipr_top.sv ***
// Local design decisions: the APB slave port and the placing of the registers.
`include "eipr_consts.svh"
module eipr_top
    import eipr_pkg::*;
(
    input  wire logic                   pclk,         // system clock
    input  wire logic                   presetn,      // async reset, power-on or pin reset
    input  wire logic                   clk_en,       // freezes all state when low
    input  wire logic                   psel,         // apb select
    input  wire logic                   penable,      // apb access phase
    input  wire logic                   pwrite,       // apb direction
    input  wire logic [7:0]             paddr,        // apb byte address
    input  wire logic [31:0]            pwdata,       // apb write data
    output logic      [31:0]            prdata,       // apb read data
    output logic                        pready,       // apb ready
    output logic                        pslverr,      // apb error on unmapped
    input  wire eipr_pkg::eipr_pincfg_t pin_cfg,      // software pin configuration
    input  wire logic [23:0]            pad_in,       // pad input levels
    output eipr_pkg::eipr_pad_t         pad,          // pad drive controls
    input  wire eipr_pkg::eipr_dbg_t    dbg,          // debugger requests
    input  wire logic                   reg_enable,   // regulator enable level
    input  wire logic [3:0]             tim_out,      // second timer channel outputs
    output logic      [3:0]             tim_in,       // second timer channel inputs
    output logic      [3:0]             ext_int,      // lines to interrupt trigger logic
    output logic                        jtag_active,  // jtag pins taken over
    output logic                        sw_active     // serial-wire pin taken over
);
    import eipr_pkg::*;

    eipr_state_t st;
    eipr_state_t next_st;
    logic [23:0] forced_dig;
    logic [23:0] din;
    logic        wr_acc;
    logic        rd_setup;
    logic        mapped;

    // pin chosen by a routing select, none above the last pin
    function automatic logic route_pin(input logic [4:0] sel, input logic [23:0] d);
        logic v;
        v = 1'b0;
        if (sel < `EIPR_SEL_LIMIT) begin
            v = d[sel];
        end
        return v;
    endfunction

    // pad pin carrying a given timer channel
    function automatic logic [4:0] tim_pin(input int ch, input logic remap);
        logic [4:0] p;
        p = `EIPR_TIM_DEF_C1;
        if (remap) begin
            p = `EIPR_TIM_REMAP_C1 + 5'(ch);
        end else begin
            case (ch)
                0:       p = `EIPR_TIM_DEF_C1;
                1:       p = `EIPR_TIM_DEF_C2;
                2:       p = `EIPR_TIM_DEF_C3;
                default: p = `EIPR_TIM_DEF_C4;
            endcase
        end
        return p;
    endfunction

    // address decode for the four registers
    function automatic logic is_mapped(input logic [7:0] a);
        return a == `EIPR_OFS_SEL3 || a == `EIPR_OFS_SEL4 ||
               a == `EIPR_OFS_DCFG || a == `EIPR_OFS_DSTAT;
    endfunction

    // debugger mode, gated by the disable control
    assign jtag_active = dbg.jtag_req & ~st.dcfg[`EIPR_DCFG_DIS];
    assign sw_active   = dbg.sw_req & ~st.dcfg[`EIPR_DCFG_DIS];

    // apb handshake, zero wait states
    assign mapped   = is_mapped(paddr);
    assign wr_acc   = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign prdata   = st.prdata;
    assign ext_int  = st.ext_int;
    assign tim_in   = st.tim_in;

    // pins whose mode is overridden to a digital role
    always_comb begin
        forced_dig = '0;
        forced_dig[`EIPR_PIN_BOOT] = ~presetn;
        forced_dig[`EIPR_PIN_REG]  = presetn;
        if (jtag_active) begin
            forced_dig[`EIPR_PIN_JTAG_RESET_PIN] = 1'b1;
            forced_dig[`EIPR_PIN_JTAG_DATA_IN_PIN] = 1'b1;
            forced_dig[`EIPR_PIN_JTAG_DATA_OUT_PIN] = 1'b1;
        end
        if (sw_active) begin
            forced_dig[`EIPR_PIN_SWDIO] = 1'b1;
        end
    end

    // digital input path: analog pins read constant one unless forced to a digital role
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pin_cfg.mode[i] == `EIPR_MODE_ANALOG && !forced_dig[i]) begin
                din[i] = 1'b1;
            end else begin
                din[i] = st.sync2[i];
            end
        end
    end

    // pad drive: configured mode first, then overrides
    always_comb begin
        logic [23:0] alt;
        alt = pin_cfg.alt_out;
        for (int c = 0; c < 4; c++) begin
            alt[tim_pin(c, st.dcfg[`EIPR_DCFG_REMAP])] = tim_out[c];
        end
        pad = '0;
        pad.oe_n = '1;
        for (int i = 0; i < NPIN; i++) begin
            case (pin_cfg.mode[i])
                `EIPR_MODE_ANALOG: begin
                    pad.oe_n[i] = 1'b1;
                end
                `EIPR_MODE_OUT_PP: begin
                    pad.out_val[i] = pin_cfg.sw_out[i];
                    pad.oe_n[i]    = 1'b0;
                end
                `EIPR_MODE_OUT_OD: begin
                    pad.oe_n[i] = pin_cfg.sw_out[i];
                end
                `EIPR_MODE_IN_PULL: begin
                    pad.pull_up[i]   = pin_cfg.sw_out[i];
                    pad.pull_down[i] = ~pin_cfg.sw_out[i];
                end
                `EIPR_MODE_ALT_PP: begin
                    pad.out_val[i] = alt[i];
                    pad.oe_n[i]    = 1'b0;
                end
                `EIPR_MODE_ALT_OD: begin
                    pad.oe_n[i] = alt[i];
                end
                default: begin
                    pad.oe_n[i] = 1'b1;
                end
            endcase
        end
        // boot pin pulled up while reset holds, sampled at the first edge after release
        if (!presetn) begin
            pad.out_val[`EIPR_PIN_BOOT]   = 1'b0;
            pad.oe_n[`EIPR_PIN_BOOT]      = 1'b1;
            pad.pull_up[`EIPR_PIN_BOOT]   = 1'b1;
            pad.pull_down[`EIPR_PIN_BOOT] = 1'b0;
        end else begin
            // regulator enable: low pulls, high releases
            pad.out_val[`EIPR_PIN_REG]   = 1'b0;
            pad.oe_n[`EIPR_PIN_REG]      = reg_enable;
            pad.pull_up[`EIPR_PIN_REG]   = 1'b0;
            pad.pull_down[`EIPR_PIN_REG] = 1'b0;
        end
        // jtag reset and data-in become pulled-up inputs
        if (jtag_active) begin
            pad.oe_n[`EIPR_PIN_JTAG_RESET_PIN]      = 1'b1;
            pad.pull_up[`EIPR_PIN_JTAG_RESET_PIN]   = 1'b1;
            pad.pull_down[`EIPR_PIN_JTAG_RESET_PIN] = 1'b0;
            pad.oe_n[`EIPR_PIN_JTAG_DATA_IN_PIN]      = 1'b1;
            pad.pull_up[`EIPR_PIN_JTAG_DATA_IN_PIN]   = 1'b1;
            pad.pull_down[`EIPR_PIN_JTAG_DATA_IN_PIN] = 1'b0;
            pad.out_val[`EIPR_PIN_JTAG_DATA_OUT_PIN]   = dbg.jtag_tdo;
            pad.oe_n[`EIPR_PIN_JTAG_DATA_OUT_PIN]      = 1'b0;
            pad.pull_up[`EIPR_PIN_JTAG_DATA_OUT_PIN]   = 1'b0;
            pad.pull_down[`EIPR_PIN_JTAG_DATA_OUT_PIN] = 1'b0;
        end
        // debugger owns direction of the data pin
        if (sw_active) begin
            pad.out_val[`EIPR_PIN_SWDIO]   = dbg.swdio_out;
            pad.oe_n[`EIPR_PIN_SWDIO]      = dbg.swdio_oe_n;
            pad.pull_up[`EIPR_PIN_SWDIO]   = 1'b0;
            pad.pull_down[`EIPR_PIN_SWDIO] = 1'b0;
        end
    end

    // next state: sync, routing, registers, boot capture
    always_comb begin
        next_st = st;
        next_st.sync1 = pad_in;
        next_st.sync2 = st.sync1;
        // fixed and routed lines share the same input path
        next_st.ext_int[0] = din[`EIPR_PIN_INT1];
        next_st.ext_int[1] = din[`EIPR_PIN_INT2];
        next_st.ext_int[2] = route_pin(st.sel3, din);
        next_st.ext_int[3] = route_pin(st.sel4, din);
        for (int c = 0; c < 4; c++) begin
            next_st.tim_in[c] = din[tim_pin(c, st.dcfg[`EIPR_DCFG_REMAP])];
        end
        // boot flag taken once, at the first edge after release
        if (!st.boot_done) begin
            next_st.boot_flag = ~pad_in[`EIPR_PIN_BOOT];
            next_st.boot_done = 1'b1;
        end
        // register writes in the access phase
        if (wr_acc) begin
            case (paddr)
                `EIPR_OFS_SEL3: next_st.sel3 = pwdata[4:0];
                `EIPR_OFS_SEL4: next_st.sel4 = pwdata[4:0];
                `EIPR_OFS_DCFG: next_st.dcfg = pwdata[3:0];
                default: next_st.dcfg = st.dcfg;
            endcase
        end
        // read data captured in the setup phase
        if (rd_setup) begin
            next_st.prdata = '0;
            case (paddr)
                `EIPR_OFS_SEL3: next_st.prdata[4:0] = st.sel3;
                `EIPR_OFS_SEL4: next_st.prdata[4:0] = st.sel4;
                `EIPR_OFS_DCFG: next_st.prdata[3:0] = st.dcfg;
                `EIPR_OFS_DSTAT: begin
                    next_st.prdata[`EIPR_DST_FORCED] = dbg.forced;
                    next_st.prdata[`EIPR_DST_SWEN]   = sw_active;
                    next_st.prdata[`EIPR_DST_BOOT]   = st.boot_flag;
                end
                default: next_st.prdata = '0;
            endcase
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.sync1     <= '1;
            st.sync2     <= '1;
            st.sel3      <= `EIPR_SEL_RST;
            st.sel4      <= `EIPR_SEL_RST;
            st.dcfg      <= `EIPR_DCFG_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end
endmodule

// *** tb/eipr_properties.sv ***
module eipr_properties
(
    input wire logic                pclk,        // clock
    input wire logic                presetn,     // reset
    input wire logic                psel,        // apb select
    input wire logic                penable,     // apb access phase
    input wire logic                pwrite,      // apb direction
    input wire logic [31:0]         pwdata,      // apb write data
    input wire logic                pready,      // apb ready
    input wire logic [7:0]          paddr,       // apb address
    input wire logic                pslverr,     // apb error
    input wire logic [23:0]         pad_in,      // pad levels
    input wire eipr_pkg::eipr_pad_t pad,         // pad controls
    input wire eipr_pkg::eipr_dbg_t dbg,         // debugger requests
    input wire logic                reg_enable,  // regulator level
    input wire logic [3:0]          ext_int,     // interrupt lines
    input wire logic                jtag_active, // jtag pins taken
    input wire logic                sw_active    // serial-wire pin taken
);
    timeunit 1ns;
    timeprecision 1ns;
    import eipr_pkg::*;
    logic [1:0] up_cnt;
    logic       dis_model;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // edges since reset, so the synchroniser history is valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    // debugger disable bit as software last wrote it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dis_model <= 1'b0;
        else if (psel && penable && pwrite && pready && paddr == 8'h08) dis_model <= pwdata[0];
    end
    int_first_a: assert property (up_cnt == 2'h3 |-> ext_int[0] == $past(pad_in[8], 3))
        else $error("first line does not follow its pin");
    int_second_a: assert property (up_cnt == 2'h3 |-> ext_int[1] == $past(pad_in[14], 3))
        else $error("second line does not follow its pin");
    boot_pull_a: assert property (disable iff (1'b0) !presetn |-> pad.oe_n[5] && pad.pull_up[5])
        else $error("boot pin not a pulled-up input in reset");
    reg_drain_a: assert property (pad.oe_n[7] == reg_enable && (reg_enable || !pad.out_val[7]))
        else $error("regulator pin not open drain");
    jtag_inputs_a: assert property (jtag_active |->
        &{pad.oe_n[16], pad.pull_up[16], pad.oe_n[19], pad.pull_up[19]})
        else $error("jtag inputs not pulled up");
    jtag_out_a: assert property (jtag_active |-> !pad.oe_n[18] && pad.out_val[18] == dbg.jtag_tdo)
        else $error("jtag data out not driven");
    swdio_pin_a: assert property (sw_active |-> pad.oe_n[20] == dbg.swdio_oe_n &&
        (pad.oe_n[20] || pad.out_val[20] == dbg.swdio_out))
        else $error("serial-wire pin not under debugger");
    jtag_req_a: assert property (jtag_active == (dbg.jtag_req && !dis_model) &&
        sw_active == (dbg.sw_req && !dis_model))
        else $error("debugger mode not gated by disable");
    err_map_a: assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("error flag wrong for address");
    cover property (jtag_active);
    cover property (sw_active && !pad.oe_n[20]);
    cover property (pslverr);
    cover property ($rose(ext_int[2]));
endmodule
bind eipr_top eipr_properties u_eipr_properties (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .paddr(paddr), .pslverr(pslverr), .pad_in(pad_in), .pad(pad), .dbg(dbg), .reg_enable(reg_enable),
    .ext_int(ext_int), .jtag_active(jtag_active), .sw_active(sw_active));

// *** tb/eipr_board.sv ***
module eipr_board
(
    input wire logic                pclk,    // clock
    input wire eipr_pkg::eipr_pad_t pad,     // device pad controls
    input wire logic [23:0]         ext,     // board level on released pins
    input wire logic                jtag_on, // debugger in jtag mode
    input wire logic                sw_on,   // debugger in serial-wire mode
    input wire logic                sw_drv,  // debugger drives the data pin
    output logic [23:0]             pad_in,  // level at each pad
    output eipr_pkg::eipr_dbg_t     dbg      // debugger requests
);
    timeunit 1ns;
    timeprecision 1ns;
    import eipr_pkg::*;
    logic tgl = 1'b0;
    // a driven pad shows the device level, a released one the board level
    always_comb begin
        for (int i = 0; i < NPIN; i++)
            pad_in[i] = pad.oe_n[i] ? ext[i] : pad.out_val[i];
    end
    // debugger data changes every cycle so stale values show
    always @(posedge pclk) begin
        tgl <= ~tgl;
        dbg.jtag_req <= jtag_on;
        dbg.sw_req <= sw_on;
        dbg.forced <= jtag_on | sw_on;
        dbg.jtag_tdo <= tgl;
        dbg.swdio_out <= ~tgl;
        dbg.swdio_oe_n <= ~(sw_on & sw_drv);
    end
endmodule

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import eipr_pkg::*;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd;
    logic         pready, pslverr, jtag_active, sw_active, er;
    logic         reg_enable = 1'b1, jtag_on = 1'b0, sw_on = 1'b0, sw_drv = 1'b0;
    logic [23:0]  ext = 24'h0, pad_in;
    logic [3:0]   tim_out = 4'h6, tim_in, ext_int;
    eipr_pincfg_t pin_cfg;
    eipr_pad_t    pad;
    eipr_dbg_t    dbg;
    int           n_mismatch = 0, cmp_count = 0;
    eipr_top u_eipr_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_cfg(pin_cfg), .pad_in(pad_in), .pad(pad), .dbg(dbg), .reg_enable(reg_enable), .tim_out(tim_out),
        .tim_in(tim_in), .ext_int(ext_int), .jtag_active(jtag_active), .sw_active(sw_active));
    eipr_board u_eipr_board (.pclk(pclk), .pad(pad), .ext(ext), .jtag_on(jtag_on), .sw_on(sw_on),
        .sw_drv(sw_drv), .pad_in(pad_in), .dbg(dbg));
    initial forever #25 pclk = ~pclk;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // three sync edges plus margin
    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        pin_cfg.mode = {NPIN{4'h4}};
        pin_cfg.sw_out = '0;
        pin_cfg.alt_out = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("sel4", 8'h04, 32'h0);
        rdchk("dcfg", 8'h08, 32'h0);
        apb(1'b1, 8'h0C, 32'h3);
        rdchk("status", 8'h0C, 32'h4);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        // walk each select value over its pin, high then low
        for (int s = 0; s < NPIN; s++) begin
            apb(1'b1, 8'h00, 32'(s));
            apb(1'b1, 8'h04, 32'(23 - s));
            ext <= 24'h1 << s;
            settle();
            chk("lines high", {1'b0, 1'b1, s == 14, s == 8}, ext_int);
            ext <= ~(24'h1 << s);
            settle();
            chk("lines low", {1'b1, 1'b0, s != 14, s != 8}, ext_int);
        end
        apb(1'b1, 8'h00, 32'd24);
        apb(1'b1, 8'h04, 32'd31);
        ext <= 24'hFFFFFF;
        settle();
        chk("no route", 32'h3, ext_int);
        rdchk("sel4 top", 8'h04, 32'h1F);
        apb(1'b1, 8'h00, 32'd7);
        reg_enable <= 1'b0;
        settle();
        chk("regulator low", 32'h0, ext_int[2]);
        reg_enable <= 1'b1;
        pin_cfg.mode[17] <= 4'h0;
        pin_cfg.mode[3] <= 4'h1;
        pin_cfg.sw_out[3] <= 1'b1;
        ext <= 24'h0;
        apb(1'b1, 8'h00, 32'd17);
        apb(1'b1, 8'h04, 32'd3);
        settle();
        chk("analog and output", 32'hC, ext_int);
        pin_cfg.mode[3:0] <= {4{4'h9}};
        pin_cfg.mode[12:9] <= {4{4'h9}};
        settle();
        chk("timer default", 32'hA, pad.out_val[3:0]);
        chk("timer in", 32'h6, tim_in);
        apb(1'b1, 8'h08, 32'h2);
        settle();
        chk("timer remap", 32'h6, pad.out_val[12:9]);
        chk("timer in remap", 32'h6, tim_in);
        jtag_on <= 1'b1;
        settle();
        chk("jtag", 32'h1, jtag_active);
        chk("jtag in pins", 32'hF, {pad.oe_n[19], pad.pull_up[19], pad.oe_n[16], pad.pull_up[16]});
        chk("jtag out pin", 32'h0, pad.oe_n[18]);
        chk("jtag out data", dbg.jtag_tdo, pad.out_val[18]);
        rdchk("status jtag", 8'h0C, 32'h5);
        apb(1'b1, 8'h08, 32'h3);
        chk("jtag disabled", 32'h0, jtag_active);
        apb(1'b1, 8'h08, 32'hC);
        rdchk("dcfg misc", 8'h08, 32'hC);
        jtag_on <= 1'b0;
        sw_on <= 1'b1;
        sw_drv <= 1'b1;
        settle();
        chk("sw pin driven", 32'h2, {sw_active, pad.oe_n[20]});
        rdchk("status sw", 8'h0C, 32'h7);
        sw_drv <= 1'b0;
        settle();
        chk("sw pin released", 32'h3, {sw_active, pad.oe_n[20]});
        sw_on <= 1'b0;
        ext <= 24'hFFFFFF;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("boot pull", 32'h3, {pad.oe_n[5], pad.pull_up[5]});
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("boot high", 8'h0C, 32'h0);
        print_verdict();
    end
endmodule
